// File: rail_seq_pkg.sv
// Package: timing constants, state encoding and output group for the rail sequencer
package rail_seq_pkg;

	localparam int unsigned CLK_FREQ_HZ = 250_000_000;

	// Qualification intervals, in their printed units
	localparam int unsigned LONG_QUAL_MS = 190;
	localparam int unsigned SHORT_QUAL_US = 30;

	// Least times round up to whole cycles
	localparam longint unsigned LONG_QUAL_CYCLES =
		(longint'(LONG_QUAL_MS) * longint'(CLK_FREQ_HZ) + 64'd999) / 64'd1000;
	localparam longint unsigned SHORT_QUAL_CYCLES =
		(longint'(SHORT_QUAL_US) * longint'(CLK_FREQ_HZ) + 64'd999_999) / 64'd1_000_000;

	localparam int unsigned TIMER_WIDTH = 26;

	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_EN_A = 5'h02,
		ST_EN_AB = 5'h04,
		ST_EN_ABC = 5'h08,
		ST_POWER_GOOD = 5'h10
	} seq_state_t;

	typedef struct packed {
		logic main_rail_ok;
		logic rail2_ok;
		logic rail3_ok;
		logic rail4_ok;
	} rail_status_t;

	typedef struct packed {
		logic enable_a;
		logic enable_b;
		logic enable_c;
		logic power_good;
	} seq_outputs_t;

	localparam seq_outputs_t OUTPUTS_RESET = 4'h0;

endpackage

// File: rail_sync.sv
// Two-flop synchroniser for the four rail comparator levels
module rail_sync (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire rail_seq_pkg::rail_status_t async_in,
	output rail_seq_pkg::rail_status_t sync_out
);
	import rail_seq_pkg::*;

	rail_status_t meta_reg;
	rail_status_t meta_next;
	rail_status_t sync_reg;
	rail_status_t sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
		if (srst_in) begin
			meta_next = '0;
			sync_next = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign sync_out = sync_reg;

endmodule

// File: qual_timer.sv
// Qualification timer: counts while its watched condition holds, restarts when it drops
module qual_timer #(
	parameter int unsigned WIDTH = rail_seq_pkg::TIMER_WIDTH
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic hold_in,
	input wire logic [WIDTH-1:0] target_in,
	output logic done_out
);
	import rail_seq_pkg::*;

	if (WIDTH < 2 || WIDTH > 32) begin
		$error("qual_timer WIDTH out of range");
	end

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;

	always_comb begin
		count_next = count_reg;
		if (srst_in || !hold_in) begin
			count_next = '0;
		end else if (count_reg != target_in) begin
			count_next = count_reg + WIDTH'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		count_reg <= count_next;
	end

	// Done only while the condition still holds, so a drop cancels at once
	assign done_out = hold_in && (count_reg == target_in);

endmodule

// File: quad_rail_sequencer_core.sv
// Four-rail power sequencer: qualified start-up and post-power-good fault handling
module quad_rail_sequencer_core #(
	parameter longint unsigned LONG_CYCLES = rail_seq_pkg::LONG_QUAL_CYCLES,
	parameter longint unsigned SHORT_CYCLES = rail_seq_pkg::SHORT_QUAL_CYCLES
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic main_rail_ok_in,
	input wire logic rail2_ok_in,
	input wire logic rail3_ok_in,
	input wire logic rail4_ok_in,
	output logic enable_a_out,
	output logic enable_b_out,
	output logic enable_c_out,
	output logic power_good_out,
	output logic post_power_mode_out
);
	import rail_seq_pkg::*;

	// Refuse intervals that the timers cannot count or that invert the order
	if (LONG_CYCLES < 2 || LONG_CYCLES >= (64'd1 << TIMER_WIDTH)) begin
		$error("LONG_CYCLES out of range");
	end
	if (SHORT_CYCLES < 2 || SHORT_CYCLES >= LONG_CYCLES) begin
		$error("SHORT_CYCLES out of range");
	end

	// Timer targets are one below the interval: done raises on the last counted cycle
	localparam logic [TIMER_WIDTH-1:0] LONG_TARGET = TIMER_WIDTH'(LONG_CYCLES - 64'd1);
	localparam logic [TIMER_WIDTH-1:0] SHORT_TARGET = TIMER_WIDTH'(SHORT_CYCLES - 64'd1);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation

	rail_status_t rails_async;
	rail_status_t rails;

	assign rails_async = '{main_rail_ok: main_rail_ok_in, rail2_ok: rail2_ok_in,
		rail3_ok: rail3_ok_in, rail4_ok: rail4_ok_in};

	rail_sync u_sync (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.async_in(rails_async),
		.sync_out(rails)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Qualification timers

	function automatic seq_outputs_t outputs_of(input seq_state_t st);
		seq_outputs_t o;
		o = OUTPUTS_RESET;
		case (st)
			ST_EN_A: o = 4'h8;
			ST_EN_AB: o = 4'hc;
			ST_EN_ABC: o = 4'he;
			ST_POWER_GOOD: o = 4'hf;
			default: o = OUTPUTS_RESET;
		endcase
		return o;
	endfunction

	seq_state_t state_reg;
	seq_state_t state_next;
	// High for the first cycle of each state, so the long and short timers start over on entry
	logic moved_reg;
	logic moved_next;

	logic all_ok;
	logic low_fault;
	logic long_hold;
	logic short_hold;
	logic fault_hold;
	logic long_done;
	logic short_done;
	logic fault_done;

	assign all_ok = rails.main_rail_ok && rails.rail2_ok && rails.rail3_ok && rails.rail4_ok;
	assign low_fault = !(rails.rail2_ok && rails.rail3_ok && rails.rail4_ok);

	// Long and short hold conditions are gated by state and by moved_reg, so a timer restarts on every state change
	always_comb begin
		long_hold = 1'b0;
		short_hold = 1'b0;
		case (state_reg)
			ST_RESET: long_hold = rails.main_rail_ok;
			ST_EN_A: short_hold = rails.main_rail_ok && rails.rail2_ok;
			ST_EN_AB: short_hold = rails.main_rail_ok && rails.rail2_ok
				&& rails.rail3_ok;
			ST_EN_ABC: long_hold = all_ok;
			default: begin
				long_hold = 1'b0;
				short_hold = 1'b0;
			end
		endcase
		// The short timer serves two states in a row; without this it would carry over
		if (moved_reg) begin
			long_hold = 1'b0;
			short_hold = 1'b0;
		end
	end

	assign fault_hold = (state_reg == ST_POWER_GOOD) && rails.main_rail_ok && low_fault;

	qual_timer #(.WIDTH(TIMER_WIDTH)) u_long_timer (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.hold_in(long_hold),
		.target_in(LONG_TARGET),
		.done_out(long_done)
	);

	qual_timer #(.WIDTH(TIMER_WIDTH)) u_short_timer (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.hold_in(short_hold),
		.target_in(SHORT_TARGET),
		.done_out(short_done)
	);

	// Separate timer so a start-up count cannot leak into the fault filter
	qual_timer #(.WIDTH(TIMER_WIDTH)) u_fault_timer (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.hold_in(fault_hold),
		.target_in(SHORT_TARGET),
		.done_out(fault_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencing state machine

	seq_outputs_t outs_reg;
	seq_outputs_t outs_next;
	logic post_reg;
	logic post_next;

	always_comb begin
		state_next = state_reg;
		post_next = post_reg;
		case (state_reg)
			ST_RESET: begin
				if (long_done) begin
					state_next = ST_EN_A;
				end
			end
			ST_EN_A: begin
				if (short_done) begin
					state_next = ST_EN_AB;
				end
			end
			ST_EN_AB: begin
				if (short_done) begin
					state_next = ST_EN_ABC;
				end
			end
			ST_EN_ABC: begin
				if (long_done) begin
					state_next = ST_POWER_GOOD;
					post_next = 1'b1;
				end
			end
			ST_POWER_GOOD: begin
				// Main rail fault is not filtered: local supplies must go at once
				if (!rails.main_rail_ok) begin
					state_next = ST_RESET;
					post_next = 1'b0;
				end else if (fault_done) begin
					state_next = ST_EN_ABC;
				end
			end
			default: begin
				state_next = ST_RESET;
				post_next = 1'b0;
			end
		endcase
		if (srst_in) begin
			state_next = ST_RESET;
			post_next = 1'b0;
		end
		moved_next = !srst_in && (state_next != state_reg);
		outs_next = outputs_of(state_next);
	end

	always_ff @(posedge clk_in) begin
		state_reg <= state_next;
		outs_reg <= outs_next;
		post_reg <= post_next;
		moved_reg <= moved_next;
	end

	assign enable_a_out = outs_reg.enable_a;
	assign enable_b_out = outs_reg.enable_b;
	assign enable_c_out = outs_reg.enable_c;
	assign power_good_out = outs_reg.power_good;
	assign post_power_mode_out = post_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	a_good_needs_enables: assert property (
		power_good_out |-> (enable_a_out && enable_b_out && enable_c_out))
		else $error("power good without all enables");

	a_ordered_enables: assert property (
		(enable_c_out |-> enable_b_out) and (enable_b_out |-> enable_a_out))
		else $error("enables out of order");

	a_reset_outputs_low: assert property (
		(state_reg == ST_RESET) |->
		(!enable_a_out && !enable_b_out && !enable_c_out && !power_good_out))
		else $error("outputs not low in reset state");

	a_main_fault_drop: assert property (
		(state_reg == ST_POWER_GOOD && !rails.main_rail_ok) |=>
		(!enable_a_out && !enable_b_out && !enable_c_out && !power_good_out))
		else $error("main fault did not drop all outputs");

	a_main_fault_restart: assert property (
		(state_reg == ST_POWER_GOOD && !rails.main_rail_ok) |=> state_reg == ST_RESET)
		else $error("main fault did not restart sequence");

	a_enable_a_waits: assert property (
		$rose(enable_a_out) |-> $past(rails.main_rail_ok, 2))
		else $error("enable_a rose without main rail ok");

	a_fault_keeps_enables: assert property (
		$fell(power_good_out) && $past(rails.main_rail_ok) && !$past(srst_in) |->
		(enable_a_out && enable_b_out && enable_c_out))
		else $error("rail fault dropped enables");

	a_enable_b_rail2: assert property (
		$rose(enable_b_out) |-> $past(rails.rail2_ok, 2) && $past(rails.main_rail_ok, 2))
		else $error("enable_b rose without rails");

	a_enable_c_rail3: assert property (
		$rose(enable_c_out) |-> $past(rails.rail3_ok, 2))
		else $error("enable_c rose without rail3");

	a_good_all_rails: assert property (
		$rose(power_good_out) |-> $past(all_ok, 2) && $past(long_hold, 2))
		else $error("power good without all rails");

	a_short_qualified: assert property (
		(state_reg == ST_EN_A && !short_hold) |=> state_reg != ST_EN_AB)
		else $error("advance without continuous qualification");

	a_post_mode_latched: assert property (
		$rose(power_good_out) |-> post_reg)
		else $error("post mode not latched");

	a_reset_leave_qualified: assert property (
		(state_reg == ST_RESET && !rails.main_rail_ok) |=> state_reg == ST_RESET)
		else $error("left reset without main rail");

	a_dwell_before_b: assert property (
		$rose(enable_a_out) |=> !enable_b_out)
		else $error("enable_b followed enable_a without qualification");

	a_dwell_before_c: assert property (
		$rose(enable_b_out) |=> !enable_c_out)
		else $error("enable_c followed enable_b without qualification");

	a_post_clear_drops: assert property (
		$fell(post_power_mode_out) |-> !enable_a_out && !power_good_out)
		else $error("post mode cleared with outputs still on");

	a_drop_keeps_post: assert property (
		$fell(power_good_out) && enable_c_out |-> post_power_mode_out)
		else $error("post mode lost on rail fault");

	a_rail_fault_filtered: assert property (
		(state_reg == ST_POWER_GOOD && rails.main_rail_ok && !low_fault) |=> power_good_out)
		else $error("power good dropped without a rail fault");

	c_power_good_reached: cover property ($rose(power_good_out));
	c_low_rail_fault: cover property (
		state_reg == ST_POWER_GOOD ##1 state_reg == ST_EN_ABC);
	c_main_rail_fault: cover property (
		state_reg == ST_POWER_GOOD ##1 state_reg == ST_RESET);
	c_qual_restart: cover property (state_reg == ST_EN_A && !short_hold);
	c_post_mode_cleared: cover property ($fell(post_power_mode_out));

endmodule

// File: regulator_model.sv
// Behavioural model of the three downstream regulators and their rail comparators
module regulator_model #(
	parameter int RAMP = 4
) (
	input wire logic clk_in,
	input wire logic [2:0] enable_in,
	input wire logic [2:0] fault_in,
	output logic [2:0] rail_ok_out
);
	int ramp_reg [3];

	// A disabled or faulted regulator falls at once; an enabled one needs a ramp time
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 3; i++) begin
			// An unknown enable before the first reset edge counts as off
			if (enable_in[i] !== 1'b1 || fault_in[i]) begin
				ramp_reg[i] <= 0;
				rail_ok_out[i] <= 1'b0;
			end else if (ramp_reg[i] < RAMP) begin
				ramp_reg[i] <= ramp_reg[i] + 1;
			end else begin
				rail_ok_out[i] <= 1'b1;
			end
		end
	end
endmodule

// File: quad_rail_sequencer_core_tb.sv
// Self-checking testbench for the four-rail sequencer
module quad_rail_sequencer_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rail_seq_pkg::*;

	localparam int LONG_N = 40;
	localparam int SHORT_N = 8;

	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic main_rail_ok_in = 1'b0;
	logic [2:0] fault = 3'h0;
	logic [2:0] rail_ok;
	logic enable_a_out, enable_b_out, enable_c_out, power_good_out, post_power_mode_out;
	seq_outputs_t outs;
	int bad_count = 0;
	int checks_done = 0;

	always #2 clk_in = ~clk_in;

	assign outs = {enable_a_out, enable_b_out, enable_c_out, power_good_out};

	quad_rail_sequencer_core #(
		.LONG_CYCLES(LONG_N),
		.SHORT_CYCLES(SHORT_N)
	) i_quad_rail_sequencer_core (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.main_rail_ok_in(main_rail_ok_in),
		.rail2_ok_in(rail_ok[0]),
		.rail3_ok_in(rail_ok[1]),
		.rail4_ok_in(rail_ok[2]),
		.enable_a_out(enable_a_out),
		.enable_b_out(enable_b_out),
		.enable_c_out(enable_c_out),
		.power_good_out(power_good_out),
		.post_power_mode_out(post_power_mode_out)
	);

	regulator_model i_regulator_model (
		.clk_in(clk_in),
		.enable_in({enable_c_out, enable_b_out, enable_a_out}),
		.fault_in(fault),
		.rail_ok_out(rail_ok)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic compare(input logic [4:0] got, input logic [4:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Outputs must keep this value for n sampled cycles
	task automatic hold_outs(input seq_outputs_t exp, input int n);
		repeat (n) begin
			@(negedge clk_in);
			compare({1'b0, outs}, {1'b0, exp});
		end
	endtask

	// Bounded wait: the step must land within n cycles
	task automatic wait_outs(input seq_outputs_t exp, input int n);
		int k;
		k = 0;
		while (outs !== exp && k < n) begin
			@(negedge clk_in);
			k++;
		end
		compare({1'b0, outs}, {1'b0, exp});
	endtask

	task automatic set_main(input logic v);
		@(posedge clk_in);
		main_rail_ok_in <= v;
	endtask

	task automatic set_fault(input logic [2:0] v);
		@(posedge clk_in);
		fault <= v;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic reset_outputs_low();
		hold_outs(4'h0, 19);
		@(posedge clk_in);
		srst_in <= 1'b0;
		hold_outs(4'h0, 4);
	endtask

	// A short main-rail pulse must not count toward the long qualification
	task automatic startup_sequence();
		set_main(1'b1);
		repeat (20) @(posedge clk_in);
		set_main(1'b0);
		repeat (2) @(posedge clk_in);
		set_main(1'b1);
		hold_outs(4'h0, LONG_N);
		wait_outs(4'h8, 10);
		hold_outs(4'h8, SHORT_N);
		wait_outs(4'hc, 20);
		hold_outs(4'hc, SHORT_N);
		wait_outs(4'he, 20);
		compare({4'h0, post_power_mode_out}, 5'h0);
		hold_outs(4'he, LONG_N);
		wait_outs(4'hf, 10);
		compare({4'h0, post_power_mode_out}, 5'h1);
	endtask

	// Rail fault after power good: glitch ignored, long fault drops only good
	// One fault cycle plus the regulator ramp keeps the glitch below the short filter
	task automatic rail_fault_in_good();
		set_fault(3'h2);
		set_fault(3'h0);
		hold_outs(4'hf, 15);
		set_fault(3'h2);
		hold_outs(4'hf, SHORT_N);
		wait_outs(4'he, 10);
		compare({4'h0, post_power_mode_out}, 5'h1);
		set_fault(3'h0);
		hold_outs(4'he, LONG_N);
		wait_outs(4'hf, 20);
	endtask

	// Main rail fault drops everything and forces the full sequence again
	task automatic main_fault_in_good();
		set_main(1'b0);
		wait_outs(4'h0, 4);
		compare({4'h0, post_power_mode_out}, 5'h0);
		hold_outs(4'h0, 10);
		set_main(1'b1);
		hold_outs(4'h0, LONG_N);
		wait_outs(4'h8, 10);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		reset_outputs_low();
		startup_sequence();
		rail_fault_in_good();
		main_fault_in_good();
		wrap_up();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end
endmodule
